// ### include/accel_regs_pkg.sv
package accel_regs_pkg;

  // Register offsets on the host byte port.
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h01;
  localparam logic [7:0] ADDR_MODE_STATUS = 8'h02;
  localparam logic [7:0] ADDR_SELF_TEST   = 8'h07;
  localparam logic [7:0] ADDR_MODE_CFG    = 8'h08;
  localparam logic [7:0] ADDR_RATE_AXIS   = 8'h09;
  localparam logic [7:0] ADDR_IRQ_ROUTE   = 8'h0a;

  // Interrupt source status bit positions.
  localparam int BIT_ACTIVITY   = 7;
  localparam int BIT_TAP        = 5;
  localparam int BIT_COMBO      = 4;
  localparam int BIT_OVERRUN    = 3;
  localparam int BIT_WATERMARK  = 2;
  localparam int BIT_SAMPLE_RDY = 1;
  localparam int BIT_INACTIVITY = 0;

  // Mode status bit positions.
  localparam int BIT_POLLED_RDY = 4;
  localparam int BIT_IN_MEASURE = 2;
  localparam int BIT_IN_WAKEUP  = 1;
  localparam int BIT_IN_PDOWN   = 0;

  // Control field positions.
  localparam int BIT_SELF_TEST  = 4;
  localparam int BIT_EXT_TRIG   = 7;
  localparam int BIT_EXT_CLOCK  = 6;
  localparam int BIT_SPI_3WIRE  = 5;
  localparam int BIT_SOFT_RST   = 4;
  localparam int BIT_LOWPASS    = 3;
  localparam int BIT_ACT_PIN2   = 7;
  localparam int BIT_INACT_PIN2 = 6;
  localparam int BIT_ACT_PIN1   = 5;
  localparam int BIT_INACT_PIN1 = 4;
  localparam int BIT_POL_PIN2   = 3;
  localparam int BIT_POL_PIN1   = 2;

  // Reset values of the writable registers.
  localparam logic [7:0] RST_SELF_TEST = 8'h00;
  localparam logic [7:0] RST_MODE_CFG  = 8'h00;
  localparam logic [7:0] RST_RATE_AXIS = 8'h07;
  localparam logic [7:0] RST_IRQ_ROUTE = 8'h00;

  // Operating-mode field codes.
  localparam logic [1:0] OPMODE_PDOWN   = 2'h0;
  localparam logic [1:0] OPMODE_WAKEUP  = 2'h1;
  localparam logic [1:0] OPMODE_MEASURE = 2'h2;

  // Timing: system clock, fastest rate, non-latched pulse width.
  localparam int SYS_HZ          = 20000000;
  localparam int RATE_MAX_HZ     = 400;
  localparam int RATE_MAX_CODE   = 6;
  localparam int WAKE_SHIFT_BASE = 8;
  localparam int WAKE_MAX_CODE   = 5;
  localparam int PULSE_NS        = 25000;
  localparam int CLK_NS          = 50;
  localparam int PULSE_CYCLES    = PULSE_NS / CLK_NS;

  typedef enum logic [1:0] {
    MODE_PDOWN,
    MODE_WAKEUP,
    MODE_MEASURE
  } op_mode_type;

endpackage : accel_regs_pkg

// ### sim/host_model.sv
`timescale 1ns/1ps
// Stand-in for the host processor on the register byte port.
module host_model (
  // Clock.
  input  wire logic       sys_clk,
  // Register byte port.
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // The port idles with both strobes low.
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One write; the data is inverted once released so stale values never pass.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : write_reg

  // One read; the answer is registered, so it is taken one edge later.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    d        = reg_rdata;
    reg_rd   = 1'b0;
  endtask : read_reg
endmodule : host_model

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
  import accel_regs_pkg::*;
  logic       sys_clk = 1'b0;
  logic       arst_n  = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic       reg_wr, reg_rd, strobe, st_en, spi3, lp;
  logic [6:0] ev      = 7'h00;
  logic [2:0] wake    = 3'h5;
  logic [2:0] axes;
  logic [1:0] ext     = 2'h0;
  logic [1:0] range, pin_out, pin_oe, pin_in;
  int         mismatches = 0;
  int         n_compared = 0;
  int         cycles     = 0;
  int         n_strobe   = 0;

  // Each pin carries the device level while enabled, else the bench level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  accel_mode_irq_control_regs #(.FAST_PERIOD(24'h10)) DUT (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .activity_detect(ev[6]),
    .inactivity_detect(ev[5]), .tap_event(ev[4]),
    .combo_motion_event(ev[3]), .buffer_full_event(ev[2]),
    .buffer_watermark_event(ev[1]), .sample_ready_event(ev[0]),
    .wake_rate_sel(wake), .pin_latched(2'h1), .sample_strobe(strobe),
    .self_test_enable(st_en), .spi_three_wire(spi3),
    .lowpass_enable(lp), .axis_enable(axes), .range_select(range),
    .irq_pin_in(pin_in), .irq_pin_out(pin_out), .irq_pin_oe(pin_oe));

  // Clock, strobe counter and the hang limit.
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (strobe === 1'b1) n_strobe++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  // Reads one register and checks it against the value the caller expects.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.read_reg(a, rd);
    check(rd, e);
  endtask : rchk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.write_reg(a, d);
  endtask : wr

  // Event pulses last exactly one cycle, as the sources make them.
  task automatic pulse(input logic [6:0] v);
    @(negedge sys_clk);
    ev = v;
    @(negedge sys_clk);
    ev = 7'h00;
  endtask : pulse

  task automatic t_reset();
    check({6'h0, pin_oe}, 8'h03);
    rchk(ADDR_SELF_TEST, 8'h00);
    rchk(ADDR_MODE_CFG, 8'h00);
    rchk(ADDR_RATE_AXIS, 8'h07);
    rchk(ADDR_IRQ_ROUTE, 8'h00);
    rchk(ADDR_MODE_STATUS, 8'h01);
    rchk(8'h03, 8'h00);
  endtask : t_reset

  task automatic t_config();
    wr(ADDR_SELF_TEST, 8'hff);
    rchk(ADDR_SELF_TEST, 8'h10);
    check({7'h0, st_en}, 8'h01);
    wr(ADDR_RATE_AXIS, 8'hf8);
    rchk(ADDR_RATE_AXIS, 8'h78);
    check({4'h0, lp, axes}, 8'h08);
    wr(ADDR_IRQ_ROUTE, 8'h03);
    check({6'h0, range}, 8'h03);
    wr(ADDR_MODE_CFG, 8'h2e);
    rchk(ADDR_MODE_CFG, 8'h22);
    check({7'h0, spi3}, 8'h01);
    rchk(ADDR_MODE_STATUS, 8'h04);
    wr(ADDR_MODE_CFG, 8'h01);
    rchk(ADDR_MODE_STATUS, 8'h02);
    // A soft reset brings every writable register back to its default.
    wr(ADDR_MODE_CFG, 8'h12);
    rchk(ADDR_RATE_AXIS, 8'h07);
    rchk(ADDR_MODE_STATUS, 8'h01);
  endtask : t_config

  task automatic t_events();
    wr(ADDR_MODE_CFG, 8'h02);
    pulse(7'h1f);
    rchk(ADDR_IRQ_STATUS, 8'h3e);
    rchk(ADDR_IRQ_STATUS, 8'h00);
    rchk(ADDR_MODE_STATUS, 8'h14);
    rchk(ADDR_MODE_STATUS, 8'h04);
  endtask : t_events

  task automatic t_modes();
    // Inactivity on pin one, active low and latched until a status read.
    wr(ADDR_IRQ_ROUTE, 8'h14);
    check({7'h0, pin_out[0]}, 8'h01);
    pulse(7'h20);
    tick(2);
    check({7'h0, pin_out[0]}, 8'h00);
    tick(40);
    check({7'h0, pin_out[0]}, 8'h00);
    rchk(ADDR_IRQ_STATUS, 8'h01);
    tick(2);
    check({7'h0, pin_out[0]}, 8'h01);
    rchk(ADDR_MODE_STATUS, 8'h02);
    // Activity on pin two, active high, a pulse of 500 cycles.
    wr(ADDR_IRQ_ROUTE, 8'h80);
    pulse(7'h40);
    tick(2);
    check({7'h0, pin_out[1]}, 8'h01);
    tick(440);
    check({7'h0, pin_out[1]}, 8'h01);
    tick(80);
    check({7'h0, pin_out[1]}, 8'h00);
    rchk(ADDR_IRQ_STATUS, 8'h80);
    rchk(ADDR_MODE_STATUS, 8'h04);
  endtask : t_modes

  // Windows are whole multiples of the period, so the phase cannot matter.
  task automatic count(input int exp);
    tick(160);
    n_strobe = 0;
    tick(256);
    check(8'(n_strobe), 8'(exp));
  endtask : count

  task automatic t_sampling();
    for (int c = 6; c >= 4; c--) begin
      wr(ADDR_RATE_AXIS, {1'b0, 3'(c), 4'h7});
      count(256 / (16 << (6 - c)));
    end
    wr(ADDR_MODE_CFG, 8'h01);
    count(2);
    // Wakeup codes above the fastest one stay at the fastest wakeup rate.
    wake = 3'h7;
    count(2);
    wr(ADDR_MODE_CFG, 8'h00);
    count(0);
    wr(ADDR_MODE_CFG, 8'h03);
    rchk(ADDR_MODE_STATUS, 8'h01);
    // External time base: sixteen pin-one rises make one fast period.
    wr(ADDR_RATE_AXIS, 8'h67);
    wr(ADDR_MODE_CFG, 8'h42);
    check({6'h0, pin_oe}, 8'h02);
    n_strobe = 0;
    repeat (16) begin
      ext = 2'h1;
      tick(4);
      ext = 2'h0;
      tick(4);
    end
    tick(4);
    check(8'(n_strobe), 8'h01);
    wr(ADDR_MODE_CFG, 8'h82);
    check({6'h0, pin_oe}, 8'h01);
    n_strobe = 0;
    ext = 2'h2;
    tick(64);
    check(8'(n_strobe), 8'h01);
  endtask : t_sampling

  task automatic report_and_stop();
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Main sequence after three cycles of reset.
  initial begin
    tick(3);
    arst_n = 1'b1;
    t_reset();
    t_config();
    t_events();
    t_modes();
    t_sampling();
    report_and_stop();
  end
endmodule : tb

// ### verilog/accel_mode_irq_control_regs.sv
`timescale 1ns/1ps
// What this block does
// - Activity wakeup-to-measure sets status bit 7.
// - Single or double tap sets bit 5.
// - Combinational motion event sets bit 4.
// - Buffer full sets bit 3, watermark 2.
// - New axis sample sets bit 1.
// - Inactivity measure-to-wakeup sets bit 0.
// - Status read clears all; mode read clears ready.
// - Mode bits show measure, wakeup, power-down.
// - Wakeup samples at 1.56 to 50 Hz.
// - Control zero bit 4 enables self-test.
// - Mode bit 7 takes sampling from pin two.
// - Mode bit 6 takes clock from pin one.
// - Mode bit 5 selects three-wire SPI.
// - Mode field: 2 measure, 1 wakeup, 0 down.
// - Rate field codes 0..6 give 6.25..400 Hz.
// - Control one bit 3 enables low-pass.
// - Control one bits 2:0 enable Z Y X.
// - Control two bits 7:4 route mode events.
// - Control two bits 3:2 set pin polarity.
// - Control two bits 1:0 select range.
// - Latched pin waits status read, else pulses.
module accel_mode_irq_control_regs
  import accel_regs_pkg::*;
#(
  parameter logic [23:0] FAST_PERIOD = 24'(SYS_HZ / RATE_MAX_HZ)
) (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Host register byte port.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Event pulses from the motion, buffer and axis paths.
  input  wire logic       activity_detect,
  input  wire logic       inactivity_detect,
  input  wire logic       tap_event,
  input  wire logic       combo_motion_event,
  input  wire logic       buffer_full_event,
  input  wire logic       buffer_watermark_event,
  input  wire logic       sample_ready_event,
  // Settings held outside this group.
  input  wire logic [2:0] wake_rate_sel,
  input  wire logic [1:0] pin_latched,
  // Settings driven to the sensor core.
  output logic            sample_strobe,
  output logic            self_test_enable,
  output logic            spi_three_wire,
  output logic            lowpass_enable,
  output logic      [2:0] axis_enable,
  output logic      [1:0] range_select,
  // Interrupt pins one (bit 0) and two (bit 1).
  input  wire logic [1:0] irq_pin_in,
  output logic      [1:0] irq_pin_out,
  output logic      [1:0] irq_pin_oe
);

  typedef struct packed {
    logic [7:0]  irq_status;
    logic        polled_ready;
    op_mode_type mode;
    logic        self_test;
    logic [3:0]  mode_cfg_hi;
    logic [1:0]  opmode_field;
    logic [6:0]  rate_axis;
    logic [7:0]  route;
    logic [23:0] rate_cnt;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [1:0]  sync3;
    logic [1:0]  pin_level;
    logic [1:0]  pin_active;
    logic [17:0] pulse_cnt;
    logic        strobe;
    logic [7:0]  rdata;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic [1:0] pin_rise;
  logic [1:0] pin_event;
  logic [1:0] pin_pol;
  logic [3:0] shamt;
  logic [2:0] wsel;
  logic [2:0] rsel;
  logic [23:0] period;
  logic        tick;
  logic        rd_sts;
  logic        rd_mode;
  logic        act_evt;
  logic        inact_evt;

  // Decode reads and the mode-change events.
  assign rd_sts    = reg_rd && (reg_addr == ADDR_IRQ_STATUS);
  assign rd_mode   = reg_rd && (reg_addr == ADDR_MODE_STATUS);
  assign act_evt   = activity_detect && (s_q.mode == MODE_WAKEUP);
  assign inact_evt = inactivity_detect && (s_q.mode == MODE_MEASURE);

  // Sample period; wakeup codes above 50 Hz clamp to 50 Hz.
  always_comb begin
    wsel = (wake_rate_sel > 3'(WAKE_MAX_CODE)) ? 3'(WAKE_MAX_CODE)
                                              : wake_rate_sel;
    rsel = (s_q.rate_axis[6:4] > 3'(RATE_MAX_CODE)) ? 3'(RATE_MAX_CODE)
                                                    : s_q.rate_axis[6:4];
    if (s_q.mode == MODE_WAKEUP) begin
      shamt = 4'(WAKE_SHIFT_BASE) - {1'b0, wsel};
    end else begin
      shamt = 4'(RATE_MAX_CODE) - {1'b0, rsel};
    end
    period = FAST_PERIOD << shamt;
  end

  // Pin change counts once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_rise[i] = (s_q.sync2[i] == s_q.sync3[i]) && s_q.sync3[i]
                    && !s_q.pin_level[i];
    end
    pin_pol = {s_q.route[BIT_POL_PIN2], s_q.route[BIT_POL_PIN1]};
    pin_event[0] = (act_evt && s_q.route[BIT_ACT_PIN1])
                || (inact_evt && s_q.route[BIT_INACT_PIN1]);
    pin_event[1] = (act_evt && s_q.route[BIT_ACT_PIN2])
                || (inact_evt && s_q.route[BIT_INACT_PIN2]);
    tick = s_q.mode_cfg_hi[BIT_EXT_CLOCK - 4] ? pin_rise[0] : 1'b1;
  end

  // Next-state logic for the whole block.
  always_comb begin
    s_d        = s_q;
    s_d.strobe = 1'b0;
    s_d.sync1  = irq_pin_in;
    s_d.sync2  = s_q.sync1;
    s_d.sync3  = s_q.sync2;
    for (int i = 0; i < 2; i++) begin
      if (s_q.sync2[i] == s_q.sync3[i]) begin
        s_d.pin_level[i] = s_q.sync3[i];
      end
    end

    if (rd_sts) begin
      s_d.irq_status = 8'h00;
    end
    if (rd_mode) begin
      s_d.polled_ready = 1'b0;
    end
    if (tap_event) s_d.irq_status[BIT_TAP] = 1'b1;
    if (combo_motion_event) s_d.irq_status[BIT_COMBO] = 1'b1;
    if (buffer_full_event) s_d.irq_status[BIT_OVERRUN] = 1'b1;
    if (buffer_watermark_event) s_d.irq_status[BIT_WATERMARK] = 1'b1;
    if (sample_ready_event) begin
      s_d.irq_status[BIT_SAMPLE_RDY] = 1'b1;
      s_d.polled_ready               = 1'b1;
    end
    if (act_evt) begin
      s_d.irq_status[BIT_ACTIVITY] = 1'b1;
      s_d.mode                     = MODE_MEASURE;
    end
    if (inact_evt) begin
      s_d.irq_status[BIT_INACTIVITY] = 1'b1;
      s_d.mode                       = MODE_WAKEUP;
    end

    // Host writes; drops unassigned bits.
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_SELF_TEST: s_d.self_test = reg_wdata[BIT_SELF_TEST];
        ADDR_MODE_CFG: begin
          if (reg_wdata[BIT_SOFT_RST]) begin
            // Soft reset restores defaults and is not stored.
            s_d.self_test    = RST_SELF_TEST[BIT_SELF_TEST];
            s_d.mode_cfg_hi  = RST_MODE_CFG[7:4];
            s_d.opmode_field = RST_MODE_CFG[1:0];
            s_d.rate_axis    = RST_RATE_AXIS[6:0];
            s_d.route        = RST_IRQ_ROUTE;
            s_d.mode         = MODE_PDOWN;
          end else begin
            s_d.mode_cfg_hi  = {reg_wdata[7:5], 1'b0};
            s_d.opmode_field = reg_wdata[1:0];
            unique case (reg_wdata[1:0])
              OPMODE_MEASURE: s_d.mode = MODE_MEASURE;
              OPMODE_WAKEUP:  s_d.mode = MODE_WAKEUP;
              default:        s_d.mode = MODE_PDOWN;
            endcase
          end
        end
        ADDR_RATE_AXIS: s_d.rate_axis = reg_wdata[6:0];
        ADDR_IRQ_ROUTE: s_d.route = reg_wdata;
        default: ;
      endcase
    end

    // Sample timing; the counter idles in power-down.
    if (s_q.mode == MODE_PDOWN) begin
      s_d.rate_cnt = 24'h000000;
    end else if (s_q.mode_cfg_hi[BIT_EXT_TRIG - 4]) begin
      s_d.rate_cnt = 24'h000000;
      s_d.strobe   = pin_rise[1];
    end else if (tick) begin
      if (s_q.rate_cnt >= period - 24'h000001) begin
        s_d.rate_cnt = 24'h000000;
        s_d.strobe   = 1'b1;
      end else begin
        s_d.rate_cnt = s_q.rate_cnt + 24'h000001;
      end
    end

    for (int i = 0; i < 2; i++) begin
      if (pin_latched[i]) begin
        s_d.pulse_cnt[i*9 +: 9] = 9'h000;
        if (pin_event[i]) begin
          s_d.pin_active[i] = 1'b1;
        end else if (rd_sts) begin
          s_d.pin_active[i] = 1'b0;
        end
      end else if (pin_event[i]) begin
        s_d.pin_active[i]       = 1'b1;
        s_d.pulse_cnt[i*9 +: 9] = 9'(PULSE_CYCLES - 1);
      end else if (s_q.pulse_cnt[i*9 +: 9] != 9'h000) begin
        s_d.pulse_cnt[i*9 +: 9] = s_q.pulse_cnt[i*9 +: 9] - 9'h001;
      end else begin
        s_d.pin_active[i] = 1'b0;
      end
    end

    // Read data; unassigned bits read zero.
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_IRQ_STATUS: s_d.rdata = s_q.irq_status;
        ADDR_MODE_STATUS: s_d.rdata = {3'h0, s_q.polled_ready, 1'b0,
                                       s_q.mode == MODE_MEASURE,
                                       s_q.mode == MODE_WAKEUP,
                                       s_q.mode == MODE_PDOWN};
        ADDR_SELF_TEST: s_d.rdata = {3'h0, s_q.self_test, 4'h0};
        ADDR_MODE_CFG:  s_d.rdata = {s_q.mode_cfg_hi, 2'h0,
                                     s_q.opmode_field};
        ADDR_RATE_AXIS: s_d.rdata = {1'b0, s_q.rate_axis};
        ADDR_IRQ_ROUTE: s_d.rdata = s_q.route;
        default:        s_d.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset loads only constants.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q              <= '0;
      s_q.mode         <= MODE_PDOWN;
      s_q.self_test    <= RST_SELF_TEST[BIT_SELF_TEST];
      s_q.mode_cfg_hi  <= RST_MODE_CFG[7:4];
      s_q.opmode_field <= RST_MODE_CFG[1:0];
      s_q.rate_axis    <= RST_RATE_AXIS[6:0];
      s_q.route        <= RST_IRQ_ROUTE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs; a pin used as an input is never driven.
  assign reg_rdata        = s_q.rdata;
  assign sample_strobe    = s_q.strobe;
  assign self_test_enable = s_q.self_test;
  assign spi_three_wire   = s_q.mode_cfg_hi[BIT_SPI_3WIRE - 4];
  assign lowpass_enable   = s_q.rate_axis[BIT_LOWPASS];
  assign axis_enable      = s_q.rate_axis[2:0];
  assign range_select     = s_q.route[1:0];
  assign irq_pin_out      = s_q.pin_active ^ pin_pol;
  assign irq_pin_oe       = ~{s_q.mode_cfg_hi[BIT_EXT_TRIG - 4],
                              s_q.mode_cfg_hi[BIT_EXT_CLOCK - 4]};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence quiet_events;
    !tap_event && !combo_motion_event && !buffer_full_event
      && !buffer_watermark_event && !sample_ready_event
      && !act_evt && !inact_evt;
  endsequence

  sequence pulse_hold;
    s_q.pin_active[1] [*8];
  endsequence

  a_status_read_clear: assert property ((rd_sts and quiet_events) |=>
    s_q.irq_status == 8'h00) else $error("status not cleared by read");
  a_mode_read_clear: assert property (rd_mode && !sample_ready_event
    |=> !s_q.polled_ready && $stable(s_q.irq_status[BIT_SAMPLE_RDY]))
    else $error("mode read cleared wrong bits");
  a_tap_sets_flag: assert property (tap_event |=>
    s_q.irq_status[BIT_TAP]) else $error("tap flag missing");
  a_combo_sets_flag: assert property (combo_motion_event |=>
    s_q.irq_status[BIT_COMBO]) else $error("combo flag missing");
  a_buffer_flags_set: assert property (buffer_full_event
    && buffer_watermark_event |=> s_q.irq_status[3:2] == 2'h3)
    else $error("buffer flags missing");
  a_ready_both_flags: assert property (sample_ready_event |=>
    s_q.irq_status[BIT_SAMPLE_RDY] && s_q.polled_ready)
    else $error("ready flags missing");
  a_activity_to_measure: assert property (act_evt && !reg_wr |=>
    s_q.irq_status[BIT_ACTIVITY] && s_q.mode == MODE_MEASURE)
    else $error("activity transition wrong");
  a_inactivity_to_wake: assert property (inact_evt && !reg_wr |=>
    s_q.irq_status[BIT_INACTIVITY] && s_q.mode == MODE_WAKEUP)
    else $error("inactivity transition wrong");
  a_mode_status_onehot: assert property (rd_mode |=>
    $onehot(reg_rdata[2:0])) else $error("mode status not one-hot");
  a_self_test_write: assert property (reg_wr && reg_addr ==
    ADDR_SELF_TEST |=> self_test_enable == $past(reg_wdata[BIT_SELF_TEST]))
    else $error("self-test write lost");
  a_ext_trigger_strobe: assert property (s_q.mode != MODE_PDOWN
    && s_q.mode_cfg_hi[BIT_EXT_TRIG - 4] && !reg_wr |=>
    sample_strobe == $past(pin_rise[1])) else $error("trigger strobe wrong");
  a_pulse_min_width: assert property (pin_event[1] && !pin_latched[1]
    |=> pulse_hold) else $error("pin pulse too short");

endmodule : accel_mode_irq_control_regs
